/* File: hdl/prio_cfg.svh */
// How it works
// - the first priority register holds the adc done level in bits 6-4 and the serial tx level in bits 2-0, other bits read zero.
// - the second register holds pin change level in 14-12, two wire master level in 6-4, two wire slave level in 2-0, others zero.
// - each 3-bit field is a level 0 to 7 and level seven wins over every lower level when requests compete.
// - level one is the lowest active level and level zero masks its source so it never requests the core.
// - after reset every field holds binary 100, level four, and every field bit is read and write.
`ifndef PRIO_CFG_SVH
`define PRIO_CFG_SVH
`define PRIO_ADDR_ADC_UART   4'h0
`define PRIO_ADDR_CN_I2C     4'h4
`define PRIO_ADDR_WINNER     4'h8
`define PRIO_LVL_RESET       3'h4
`define PRIO_LVL_OFF         3'h0
`define PRIO_BIT_ADC         4
`define PRIO_BIT_UTX         0
`define PRIO_BIT_CN          12
`define PRIO_BIT_MST         4
`define PRIO_BIT_SLV         0
`define PRIO_BIT_WIN_V       7
`define PRIO_BIT_WIN_L       4
`define PRIO_BIT_WIN_I       0
`define PRIO_NUM_SRC         5
`endif

/* File: hdl/prio_pkg.sv */
package prio_pkg;
   typedef logic [2:0] level_t;
   typedef struct packed
   {
      level_t adc_done_level;
      level_t serial_tx_level;
      level_t pin_change_level;
      level_t two_wire_master_level;
      level_t two_wire_slave_level;
   } levels_t;
   typedef struct packed
   {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } av_req_t;
   typedef struct packed
   {
      logic [31:0] readdata;
      logic        waitrequest;
      logic        readdatavalid;
   } av_rsp_t;
endpackage

/* File: hdl/prio_pick.sv */
`include "prio_cfg.svh"
// picks the highest-level pending source; ties go to the lowest index
module prio_pick #(
   parameter int N = `PRIO_NUM_SRC
) (
   input  wire logic [N-1:0]   pending,    // raw requests
   input  wire logic [3*N-1:0] levels,     // packed levels, source 0 low
   output logic                any_valid,  // some unmasked request pending
   output logic [2:0]          win_level,  // winning level
   output logic [2:0]          win_index   // winning source index
);
   logic [2:0] lv [N+1];
   logic [2:0] ix [N+1];
   assign lv[0] = `PRIO_LVL_OFF;
   assign ix[0] = 3'h0;
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_src
         logic [2:0] l;
         assign l = levels[3*g +: 3];
         // zero never beats the seed, so a masked source never wins
         assign lv[g+1] = (pending[g] && l > lv[g]) ? l : lv[g];
         assign ix[g+1] = (pending[g] && l > lv[g]) ? 3'(g) : ix[g];
      end
   endgenerate
   assign any_valid = (lv[N] != `PRIO_LVL_OFF);
   assign win_level = lv[N];
   assign win_index = ix[N];
endmodule

/* File: hdl/prio_regs.sv */
`include "prio_cfg.svh"
module prio_regs (
   input  wire logic             clock,       // 20 MHz system clock
   input  wire logic             sys_rst,     // synchronous reset, high
   input  wire logic             clk_en,      // freezes all state when low
   input  wire prio_pkg::av_req_t av_req,     // avalon request
   output prio_pkg::av_rsp_t     av_rsp,      // avalon answer
   input  wire logic [4:0]       src_pending, // same-clock requests
   output prio_pkg::levels_t     levels,      // levels to arbiter
   output logic                  irq_valid,   // winner exists
   output logic [2:0]            irq_level,   // winner level
   output logic [2:0]            irq_index    // winner source
);
   import prio_pkg::*;

   // ---------------------------------------------------
   // state
   // ---------------------------------------------------
   typedef struct packed
   {
      levels_t     lv;
      logic [31:0] rdata;
      logic        rvalid;
      logic        wreq;
      logic        win_v;
      logic [2:0]  win_l;
      logic [2:0]  win_i;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic       p_valid;
   logic [2:0] p_level;
   logic [2:0] p_index;
   logic [14:0] packed_lv;

   assign packed_lv = {st_q.lv.adc_done_level, st_q.lv.serial_tx_level, st_q.lv.pin_change_level,
                       st_q.lv.two_wire_master_level, st_q.lv.two_wire_slave_level};

   prio_pick #(.N(`PRIO_NUM_SRC)) u_pick (
      .pending   (src_pending),
      .levels    (packed_lv),
      .any_valid (p_valid),
      .win_level (p_level),
      .win_index (p_index)
   );

   // ---------------------------------------------------
   // next state
   // ---------------------------------------------------
   always_comb
   begin
      logic hit;
      logic [15:0] w;
      st_d = st_q;
      // a write is committed at the take edge and the answer edge only ends the access,
      // so a clk_en freeze between the two holds waitrequest low longer but cannot lose the write
      hit = (av_req.read || av_req.write) && st_q.wreq;
      w = {av_req.byteenable[1] ? av_req.writedata[15:8] : 8'h00,
           av_req.byteenable[0] ? av_req.writedata[7:0] : 8'h00};
      st_d.wreq = !hit;
      st_d.rvalid = hit && av_req.read;
      st_d.win_v = p_valid;
      st_d.win_l = p_level;
      st_d.win_i = p_index;
      if (hit && av_req.write)
      begin
         // only field bits are stored, others are dropped
         case (av_req.address)
            `PRIO_ADDR_ADC_UART:
            begin
               if (av_req.byteenable[0])
               begin
                  st_d.lv.adc_done_level  = w[`PRIO_BIT_ADC +: 3];
                  st_d.lv.serial_tx_level = w[`PRIO_BIT_UTX +: 3];
               end
            end
            `PRIO_ADDR_CN_I2C:
            begin
               if (av_req.byteenable[1])
                  st_d.lv.pin_change_level = w[`PRIO_BIT_CN +: 3];
               if (av_req.byteenable[0])
               begin
                  st_d.lv.two_wire_master_level = w[`PRIO_BIT_MST +: 3];
                  st_d.lv.two_wire_slave_level  = w[`PRIO_BIT_SLV +: 3];
               end
            end
            default:
            begin
            end
         endcase
      end
      if (hit && av_req.read)
      begin
         st_d.rdata = 32'h0000_0000;
         case (av_req.address)
            `PRIO_ADDR_ADC_UART:
            begin
               st_d.rdata[`PRIO_BIT_ADC +: 3] = st_q.lv.adc_done_level;
               st_d.rdata[`PRIO_BIT_UTX +: 3] = st_q.lv.serial_tx_level;
            end
            `PRIO_ADDR_CN_I2C:
            begin
               st_d.rdata[`PRIO_BIT_CN +: 3]  = st_q.lv.pin_change_level;
               st_d.rdata[`PRIO_BIT_MST +: 3] = st_q.lv.two_wire_master_level;
               st_d.rdata[`PRIO_BIT_SLV +: 3] = st_q.lv.two_wire_slave_level;
            end
            `PRIO_ADDR_WINNER:
            begin
               st_d.rdata[`PRIO_BIT_WIN_V]      = st_q.win_v;
               st_d.rdata[`PRIO_BIT_WIN_L +: 3] = st_q.win_l;
               st_d.rdata[`PRIO_BIT_WIN_I +: 3] = st_q.win_i;
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
         st_q.lv <= {`PRIO_NUM_SRC{`PRIO_LVL_RESET}};
         st_q.wreq <= 1'b1;
      end
      else if (clk_en)
         st_q <= st_d;
   end

   // ---------------------------------------------------
   // outputs
   // ---------------------------------------------------
   // waitrequest is low only in the answer cycle, so every access takes two cycles
   // held in its own flop so the bus sees no logic between state and pin
   assign av_rsp.waitrequest   = st_q.wreq;
   assign av_rsp.readdata      = st_q.rdata;
   assign av_rsp.readdatavalid = st_q.rvalid;
   assign levels    = st_q.lv;
   assign irq_valid = st_q.win_v;
   assign irq_level = st_q.win_l;
   assign irq_index = st_q.win_i;

   // ---------------------------------------------------
   // checks
   // ---------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // reset image
   a_reset_level_four: assert property ($past(sys_rst)
      |-> levels == {`PRIO_NUM_SRC{`PRIO_LVL_RESET}})
      else $error("levels not four after reset");
   a_reset_bus_idle: assert property ($past(sys_rst)
      |-> av_rsp.waitrequest && !av_rsp.readdatavalid && !irq_valid)
      else $error("bus or winner not idle after reset");

   // read image: readdata was built in the take cycle, and a read moves no level
   a_unimpl_reads_zero: assert property (av_rsp.readdatavalid
      && $past(av_req.address) == `PRIO_ADDR_ADC_UART
      |-> (av_rsp.readdata & 32'hFFFF_FF88) == 32'h0000_0000)
      else $error("unimplemented bits not zero");
   a_unimpl_cn_zero: assert property (av_rsp.readdatavalid
      && $past(av_req.address) == `PRIO_ADDR_CN_I2C
      |-> (av_rsp.readdata & 32'hFFFF_8F88) == 32'h0000_0000)
      else $error("unimplemented bits of second register not zero");
   a_adc_tx_fields: assert property (av_rsp.readdatavalid
      && $past(av_req.address) == `PRIO_ADDR_ADC_UART
      |-> av_rsp.readdata[`PRIO_BIT_ADC +: 3] == levels.adc_done_level
      && av_rsp.readdata[`PRIO_BIT_UTX +: 3] == levels.serial_tx_level)
      else $error("first register fields misplaced");
   a_master_field: assert property (av_rsp.readdatavalid
      && $past(av_req.address) == `PRIO_ADDR_CN_I2C
      |-> av_rsp.readdata[`PRIO_BIT_MST +: 3] == levels.two_wire_master_level)
      else $error("master field misplaced");
   a_cn_slave_fields: assert property (av_rsp.readdatavalid
      && $past(av_req.address) == `PRIO_ADDR_CN_I2C
      |-> av_rsp.readdata[`PRIO_BIT_CN +: 3] == levels.pin_change_level
      && av_rsp.readdata[`PRIO_BIT_SLV +: 3] == levels.two_wire_slave_level)
      else $error("second register fields misplaced");

   // write path
   a_write_next_cycle: assert property (clk_en && av_req.write && !av_rsp.waitrequest
      && av_req.address == `PRIO_ADDR_ADC_UART && av_req.byteenable[0]
      |=> levels.serial_tx_level == $past(av_req.writedata[`PRIO_BIT_UTX +: 3]))
      else $error("tx level not updated");
   a_adc_write_takes: assert property (clk_en && av_req.write && !av_rsp.waitrequest
      && av_req.address == `PRIO_ADDR_ADC_UART && av_req.byteenable[0]
      |=> levels.adc_done_level == $past(av_req.writedata[`PRIO_BIT_ADC +: 3]))
      else $error("adc level not updated");
   a_cn_write_takes: assert property (clk_en && av_req.write && !av_rsp.waitrequest
      && av_req.address == `PRIO_ADDR_CN_I2C && av_req.byteenable[1]
      |=> levels.pin_change_level == $past(av_req.writedata[`PRIO_BIT_CN +: 3]))
      else $error("pin change level not updated");

   // arbitration
   a_masked_no_win: assert property (clk_en && levels.adc_done_level == `PRIO_LVL_OFF
      |=> !(irq_valid && irq_index == 3'h4))
      else $error("masked source won");
   a_slave_never_wins: assert property (clk_en && levels.two_wire_slave_level == `PRIO_LVL_OFF
      |=> !(irq_valid && irq_index == 3'h0))
      else $error("masked slave source won");
   a_top_level_wins: assert property (clk_en && src_pending[4]
      && levels.adc_done_level == 3'h7
      |=> irq_valid && irq_level == 3'h7)
      else $error("level seven lost");

   // bus timing and freeze
   a_wait_one_cycle: assert property (clk_en && (av_req.read || av_req.write)
      && av_rsp.waitrequest
      |=> !av_rsp.waitrequest)
      else $error("answer late");
   a_freeze_holds: assert property (!clk_en
      |=> $stable(levels) && $stable(irq_level) && $stable(irq_index))
      else $error("state moved while frozen");
   c_write_reg: cover property (av_req.write && !av_rsp.waitrequest);
   c_read_reg: cover property (av_rsp.readdatavalid);
   c_masked: cover property (src_pending != 5'h0 && !p_valid);
   c_level_seven: cover property (irq_valid && irq_level == 3'h7);
   c_frozen: cover property (!clk_en && src_pending != 5'h0);
endmodule

/* File: sim/test_interrupt_priority_fields.sv */
`include "prio_cfg.svh"
module test_interrupt_priority_fields;
   timeunit 1ns;
   timeprecision 1ns;
   import prio_pkg::*;
   // ------------------------------------------------
   // clock, reset and the block
   // ------------------------------------------------
   logic        clock       = 1'b0;
   logic        sys_rst     = 1'b1;
   logic        clk_en      = 1'b1;
   av_req_t     av_req      = '0;
   av_rsp_t     av_rsp;
   logic [4:0]  src_pending = 5'h00;
   levels_t     levels;
   logic        irq_valid;
   logic [2:0]  irq_level;
   logic [2:0]  irq_index;
   logic [31:0] rnd         = 32'hb1e4_dfe9;
   logic [31:0] exp_q[$];
   logic [15:0] r0          = 16'h0044;
   logic [15:0] r1          = 16'h4044;
   int          n_errors    = 0;
   int          n_compared  = 0;
   int          cycles      = 0;
   always #25 clock = ~clock;
   prio_regs dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .av_req(av_req), .av_rsp(av_rsp),
      .src_pending(src_pending), .levels(levels), .irq_valid(irq_valid), .irq_level(irq_level),
      .irq_index(irq_index));
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic close_out;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
   endfunction
   function automatic levels_t lv();
      return {r0[6:4], r0[2:0], r1[14:12], r1[6:4], r1[2:0]};
   endfunction
   // strict compare keeps ties on the lowest index; level zero never beats zero
   function automatic logic [31:0] win(input logic [4:0] p, input logic [14:0] f);
      logic [2:0] bl;
      logic [2:0] bi;
      logic       v;
      {v, bl, bi} = 7'h00;
      for (int i = 0; i < 5; i++)
         if (p[i] && f[3*i+:3] > bl)
            {v, bl, bi} = {1'b1, f[3*i+:3], 3'(i)};
      return {24'h0000_00, v, bl, 1'b0, bi};
   endfunction
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         close_out();
      end
   end
   // read data is taken at the rising edge where waitrequest is seen low
   always @(posedge clock)
      if (av_rsp.readdatavalid === 1'b1 && av_rsp.waitrequest === 1'b0)
         check(av_rsp.readdata, exp_q.pop_front());
   // ------------------------------------------------
   // avalon master
   // ------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clock);
      av_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
      // the request stands through the rising edge that samples waitrequest low
      do @(posedge clock); while (av_rsp.waitrequest !== 1'b0);
      av_req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      bus(1'b1, a, d, be);
      if (a == `PRIO_ADDR_ADC_UART)
         r0 = (r0 & ~m | d[15:0] & m) & 16'h0077;
      else if (a == `PRIO_ADDR_CN_I2C)
         r1 = (r1 & ~m | d[15:0] & m) & 16'h7077;
      @(negedge clock);
      check(levels, lv());
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      rd(`PRIO_ADDR_ADC_UART, 32'h0000_0044);
      rd(`PRIO_ADDR_CN_I2C, 32'h0000_4044);
      wr(`PRIO_ADDR_ADC_UART, 32'hffff_ffff, 4'hf);
      rd(`PRIO_ADDR_ADC_UART, 32'h0000_0077);
      wr(`PRIO_ADDR_CN_I2C, 32'hffff_ffff, 4'hf);
      rd(`PRIO_ADDR_CN_I2C, 32'h0000_7077);
      wr(4'hc, 32'h0000_0000, 4'hf);
      wr(`PRIO_ADDR_WINNER, 32'h0000_0000, 4'hf);
      rd(4'hc, 32'h0000_0000);
      src_pending <= 5'h1f;
      rd(`PRIO_ADDR_WINNER, 32'h0000_00f0);
      wr(`PRIO_ADDR_ADC_UART, 32'h0000_0010, 4'h3);
      wr(`PRIO_ADDR_CN_I2C, 32'h0000_0000, 4'h3);
      rd(`PRIO_ADDR_WINNER, 32'h0000_0094);
      repeat (40)
      begin
         rnd = lfsr(rnd);
         wr(rnd[0] ? `PRIO_ADDR_CN_I2C : `PRIO_ADDR_ADC_UART, rnd, {2'b00, rnd[9:8]});
         rd(rnd[0] ? `PRIO_ADDR_CN_I2C : `PRIO_ADDR_ADC_UART, {16'h0000, rnd[0] ? r1 : r0});
         src_pending <= rnd[28:24];
         rd(`PRIO_ADDR_WINNER, win(rnd[28:24], lv()));
         @(negedge clock);
         check({24'h0000_00, irq_valid, irq_level, 1'b0, irq_index}, win(rnd[28:24], lv()));
      end
      // freeze: the winner must hold although the requests change
      @(posedge clock);
      clk_en <= 1'b0;
      src_pending <= ~rnd[28:24];
      repeat (3) @(posedge clock);
      @(negedge clock);
      check({24'h0000_00, irq_valid, irq_level, 1'b0, irq_index}, win(rnd[28:24], lv()));
      @(posedge clock);
      clk_en <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check({24'h0000_00, irq_valid, irq_level, 1'b0, irq_index}, win(~rnd[28:24], lv()));
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      r0 = 16'h0044;
      r1 = 16'h4044;
      rd(`PRIO_ADDR_ADC_UART, 32'h0000_0044);
      rd(`PRIO_ADDR_CN_I2C, 32'h0000_4044);
      @(negedge clock);
      check(levels, lv());
      check(exp_q.size(), 0);
      close_out();
   end
endmodule
